// file: irc_ctrl_model.sv
`timescale 1ns/1ps
module irc_ctrl_model (
    input wire logic i_clk_sys,
    input wire logic i_rx,
    output logic o_sclk,
    output logic o_tx
);
    initial begin
        o_sclk = 1'b0;
        o_tx = 1'b1;
    end

    // One bit per serial clock; data moves in the low half, far from the rise
    task automatic xfer(input logic [31:0] b, input int n, input int slow,
                        output logic [31:0] rx);
        rx = '1;
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk_sys);
            o_sclk <= 1'b0;
            // Random setup inside a fixed low half keeps the 160 ns serial period
            repeat (slow) @(posedge i_clk_sys);
            o_tx <= b[k];
            repeat (4 - slow) @(posedge i_clk_sys);
            rx[k] = i_rx;  // Answer launched at the previous rise still stands
            o_sclk <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys);
        o_sclk <= 1'b0;  // Clock stands still between frames
    endtask : xfer
endmodule : irc_ctrl_model

// file: irc_pkg.sv
package irc_pkg;

    // Main control register indices (4-bit command index field)
    localparam logic [3:0] IRC_IDX_COMMON = 4'h0;
    localparam logic [3:0] IRC_IDX_MODE = 4'h1;
    localparam logic [3:0] IRC_IDX_LED = 4'h2;
    localparam logic [3:0] IRC_IDX_RESET = 4'hD;
    localparam logic [3:0] IRC_IDX_EXT = 4'hF;

    // Extended indexed register indices
    localparam logic [7:0] IRC_EIDX_MAKER = 8'h00;
    localparam logic [7:0] IRC_EIDX_PART = 8'h01;
    localparam logic [7:0] IRC_EIDX_RECOVERY = 8'h04;
    localparam logic [7:0] IRC_EIDX_SETTLING = 8'h05;
    localparam logic [7:0] IRC_EIDX_CAPS = 8'h06;
    localparam logic [7:0] IRC_EIDX_MODES_LO = 8'h07;
    localparam logic [7:0] IRC_EIDX_MODES_HI = 8'h08;

    // Fixed capability values
    localparam logic [7:0] IRC_VAL_RECOVERY = 8'h24;
    localparam logic [7:0] IRC_VAL_SETTLING = 8'h30;
    localparam logic [7:0] IRC_VAL_CAPS = 8'h03;
    localparam logic [7:0] IRC_VAL_MODES_LO = 8'h0F;
    localparam logic [7:0] IRC_VAL_MODES_HI = 8'h01;

    // Reset values and writable masks
    localparam logic [7:0] IRC_RST_COMMON = 8'h17;
    localparam logic [7:0] IRC_RST_MODE = 8'h00;
    localparam logic [7:0] IRC_RST_LED = 8'h70;
    localparam logic [7:0] IRC_MASK_COMMON = 8'h17;
    localparam logic [7:0] IRC_MASK_LED = 8'hF0;

    // Common control field positions
    localparam int IRC_BIT_POWER = 0;
    localparam int IRC_BIT_RECEIVER_OUTPUT_ENABLE = 1;
    localparam int IRC_BIT_LED_EN = 2;
    localparam int IRC_BIT_ACK_EN = 4;

    // Accepted infrared mode values
    localparam logic [7:0] IRC_MODE_SIR = 8'h00;
    localparam logic [7:0] IRC_MODE_MIR = 8'h01;
    localparam logic [7:0] IRC_MODE_FIR = 8'h02;
    localparam logic [7:0] IRC_MODE_ALT = 8'h03;
    localparam logic [7:0] IRC_MODE_SHARP = 8'h08;

    // Addresses
    localparam logic [2:0] IRC_ADDR_BCAST = 3'b111;
    localparam logic [2:0] IRC_ADDR_OWN = 3'b001;

    // Emitter current per drive-level code, in mA
    localparam logic [9:0] IRC_MA_SWITCHED = 10'd550;
    localparam logic [9:0] IRC_MA_7 = 10'd250;
    localparam logic [9:0] IRC_MA_6 = 10'd125;
    localparam logic [9:0] IRC_MA_5 = 10'd60;
    localparam logic [9:0] IRC_MA_4 = 10'd45;
    localparam logic [9:0] IRC_MA_3 = 10'd30;
    localparam logic [9:0] IRC_MA_2 = 10'd15;
    localparam logic [9:0] IRC_MA_1 = 10'd8;
    localparam logic [9:0] IRC_MA_0 = 10'd0;

    // Serial clock cycles of low command line that force resynchronisation
    localparam logic [4:0] IRC_RESYNC_CYCLES = 5'd30;

    // Frame field counts, counted from the bit after the second sync bit
    localparam logic [3:0] IRC_HEAD_LAST_RD = 4'd7;
    localparam logic [3:0] IRC_HEAD_LAST_WR = 4'd8;
    localparam logic [3:0] IRC_BYTE_LAST = 4'd7;

    // Frame header as received: direction, index, address, flag (bit 0 first)
    typedef struct packed {
        logic more;
        logic [2:0] addr;
        logic [3:0] index;
        logic dir_write;
    } irc_head_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HEAD = 5'b00010,
        ST_DATA = 5'b00100,
        ST_RESP = 5'b01000,
        ST_ACK = 5'b10000
    } irc_state_e;

endpackage : irc_pkg

// file: irc_serial_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Upper nibble of LED drive level selects emitter current; code 7 is the default.
// - Read-only extended space by 8-bit index holds IDs and fixed capabilities.
// - Undecodable commands or indices change no register or configuration.
// - Undecodable read command starts no response phase.
// - Any rejected write gets no acknowledge pulse, whatever the enable says.
// - Read of an index that has no read access stays silent.
// - Write of an unsupported mode value loads the default mode 00 instead and is not acknowledged.
// - Reads addressed to broadcast address 111 are never answered.
// - No reaction leaves the answer line idle, no respond phase entered.
// - Defaults are restored by i_reset, by line monitoring and by the reset command at index D.
// - Command line is watched in every state, counting low serial clocks.
// - Thirty low clocks return to command start and reload every default.
// - Acknowledge pulse is one clock low after good individual writes.
// - Command bits are sampled on the rising serial clock edge.
// - Indices, addresses and data travel least significant bit first.
// - Own address and broadcast are served; other addresses are followed only.
module irc_serial_ctrl
    import irc_pkg::*;
#(
    parameter logic [2:0] OWN_ADDR = IRC_ADDR_OWN,
    parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value
    parameter logic [7:0] PART_ID = 8'hA5    // Arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_tx_command_line,
    output logic o_rx_answer_line,
    output logic o_rx_answer_oe,
    output logic o_power_normal,
    output logic o_receiver_output_enable,
    output logic o_led_enable,
    output logic o_ack_pulse_enable,
    output logic [7:0] o_ir_mode,
    output logic [3:0] o_led_drive_level,
    output logic [9:0] o_led_current_ma
);

    logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
    logic tx_meta_reg, tx_sync_reg;
    logic [4:0] low_cnt_reg;
    irc_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [8:0] head_reg;
    logic [7:0] data_reg;
    logic [6:0] resp_reg;
    logic [7:0] common_reg, mode_reg, led_reg;

    logic rise, resync;
    irc_head_s head_now;
    logic [7:0] data_now;
    logic mine, bcast, served, head_end, data_end;
    logic wr_ok, rd_ok, ack_ok, do_write, do_special, go_resp, go_ack, go_ext;
    logic [7:0] rd_val, wr_val;
    logic [8:0] ext_hit;

    // Two flip-flops on each pin; the serial clock is only sampled here
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            tx_meta_reg <= 1'b0;
            tx_sync_reg <= 1'b0;
        end else begin
            sclk_meta_reg <= i_sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            tx_meta_reg <= i_tx_command_line;
            tx_sync_reg <= tx_meta_reg;
        end
    end

    assign rise = sclk_sync_reg & ~sclk_prev_reg;

    // Low-line watchdog runs in every state; saturates so a long low keeps resyncing
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            low_cnt_reg <= 5'd0;
        end else if (rise) begin
            if (tx_sync_reg) begin
                low_cnt_reg <= 5'd0;
            end else if (low_cnt_reg != IRC_RESYNC_CYCLES) begin
                low_cnt_reg <= low_cnt_reg + 5'd1;
            end
        end
    end

    assign resync = rise && !tx_sync_reg && (low_cnt_reg >= IRC_RESYNC_CYCLES - 5'd1);

    // Fixed read-only extended space
    function automatic logic [8:0] ext_lookup(input logic [7:0] eidx);
        logic [8:0] r;
        r = 9'h000;
        unique case (eidx)
            IRC_EIDX_MAKER: r = {1'b1, MAKER_ID};
            IRC_EIDX_PART: r = {1'b1, PART_ID};
            IRC_EIDX_RECOVERY: r = {1'b1, IRC_VAL_RECOVERY};
            IRC_EIDX_SETTLING: r = {1'b1, IRC_VAL_SETTLING};
            IRC_EIDX_CAPS: r = {1'b1, IRC_VAL_CAPS};
            IRC_EIDX_MODES_LO: r = {1'b1, IRC_VAL_MODES_LO};
            IRC_EIDX_MODES_HI: r = {1'b1, IRC_VAL_MODES_HI};
            default: r = 9'h000; // Unknown index: no answer
        endcase
        return r;
    endfunction : ext_lookup

    // Current field and byte as they stand including the bit on the line now
    always_comb begin
        head_now = irc_head_s'(head_reg);
        if (state_reg == ST_HEAD) begin
            head_now = irc_head_s'(head_reg | (9'(tx_sync_reg) << cnt_reg));
        end
        data_now = data_reg | (8'(tx_sync_reg) << cnt_reg[2:0]);
    end

    assign mine = (head_now.addr == OWN_ADDR);
    assign bcast = (head_now.addr == IRC_ADDR_BCAST);
    assign served = mine || bcast;
    assign ack_ok = mine && !bcast && common_reg[IRC_BIT_ACK_EN]
                    && common_reg[IRC_BIT_RECEIVER_OUTPUT_ENABLE];
    assign head_end = (state_reg == ST_HEAD) && rise && ((cnt_reg == IRC_HEAD_LAST_RD
                      && !head_now.dir_write) || cnt_reg == IRC_HEAD_LAST_WR);
    assign data_end = (state_reg == ST_DATA) && rise && (cnt_reg == IRC_BYTE_LAST);

    // Decode of write legality and the value to store
    always_comb begin
        wr_ok = 1'b0;
        wr_val = 8'h00;
        unique case (head_now.index)
            IRC_IDX_COMMON: begin
                wr_ok = 1'b1;
                wr_val = data_now & IRC_MASK_COMMON;
            end
            IRC_IDX_MODE: begin
                wr_val = data_now;
                wr_ok = (data_now == IRC_MODE_SIR) || (data_now == IRC_MODE_MIR)
                        || (data_now == IRC_MODE_FIR) || (data_now == IRC_MODE_ALT)
                        || (data_now == IRC_MODE_SHARP);
            end
            IRC_IDX_LED: begin
                wr_ok = 1'b1;
                wr_val = data_now & IRC_MASK_LED;
            end
            default: wr_ok = 1'b0;
        endcase
    end

    // Decode of read legality and the value to return
    always_comb begin
        ext_hit = ext_lookup(data_now);
        rd_ok = 1'b0;
        rd_val = 8'h00;
        unique case (head_now.index)
            IRC_IDX_COMMON: begin
                rd_ok = 1'b1;
                rd_val = common_reg;
            end
            IRC_IDX_MODE: begin
                rd_ok = 1'b1;
                rd_val = mode_reg;
            end
            IRC_IDX_LED: begin
                rd_ok = 1'b1;
                rd_val = led_reg;
            end
            IRC_IDX_EXT: begin
                rd_ok = ext_hit[8];
                rd_val = ext_hit[7:0];
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // Frame outcome events; broadcast reads and rejected writes stay quiet
    always_comb begin
        go_ext = head_end && !head_now.dir_write && head_now.index == IRC_IDX_EXT;
        do_special = head_end && head_now.dir_write && !head_now.more
                     && head_now.index == IRC_IDX_RESET && served;
        do_write = data_end && head_now.dir_write && served && wr_ok;
        go_resp = ((head_end && !head_now.dir_write && !go_ext) ||
                   (data_end && !head_now.dir_write))
                  && mine && !bcast && rd_ok && common_reg[IRC_BIT_RECEIVER_OUTPUT_ENABLE];
        go_ack = ((do_special || (do_write && (head_now.index != IRC_IDX_MODE || wr_ok)))
                  && ack_ok);
    end

    // Frame sequencer; the watchdog overrides everything
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || resync) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'd0;
            head_reg <= 9'h000;
            data_reg <= 8'h00;
            resp_reg <= 7'h00;
        end else if (rise) begin
            unique case (state_reg)
                ST_IDLE: begin
                    // A one after the low sync bit opens a frame
                    if (tx_sync_reg) begin
                        state_reg <= ST_HEAD;
                        cnt_reg <= 4'd0;
                        head_reg <= 9'h000;
                        data_reg <= 8'h00;
                    end
                end
                ST_HEAD: begin
                    head_reg <= head_now;
                    cnt_reg <= cnt_reg + 4'd1;
                    if (head_end) begin
                        cnt_reg <= 4'd0;
                        if (go_resp) begin
                            state_reg <= ST_RESP;
                        end else if (go_ack) begin
                            state_reg <= ST_ACK;
                        end else if (go_ext || (head_now.dir_write && head_now.more)) begin
                            state_reg <= ST_DATA;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_DATA: begin
                    data_reg <= data_now;
                    cnt_reg <= cnt_reg + 4'd1;
                    if (data_end) begin
                        cnt_reg <= 4'd0;
                        if (go_resp) begin
                            state_reg <= ST_RESP;
                        end else if (go_ack) begin
                            state_reg <= ST_ACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RESP: begin
                    resp_reg <= resp_reg >> 1;
                    cnt_reg <= cnt_reg + 4'd1;
                    if (cnt_reg == IRC_BYTE_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (go_resp) begin
                resp_reg <= rd_val[7:1];
            end
        end
    end

    // Answer line: driven only while answering or acknowledging
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || resync) begin
            o_rx_answer_line <= 1'b1;
            o_rx_answer_oe <= 1'b0;
        end else if (rise) begin
            if (go_resp) begin
                o_rx_answer_line <= rd_val[0];
                o_rx_answer_oe <= 1'b1;
            end else if (go_ack) begin
                o_rx_answer_line <= 1'b0;
                o_rx_answer_oe <= 1'b1;
            end else if (state_reg == ST_RESP && cnt_reg != IRC_BYTE_LAST) begin
                o_rx_answer_line <= resp_reg[0];
            end else begin
                o_rx_answer_line <= 1'b1;
                o_rx_answer_oe <= 1'b0;
            end
        end
    end

    // Configuration registers; an unsupported mode write loads the default mode, other rejected writes leave them untouched
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || resync || do_special) begin
            common_reg <= IRC_RST_COMMON;
            mode_reg <= IRC_RST_MODE;
            led_reg <= IRC_RST_LED;
        end else if (data_end && head_now.dir_write && served) begin
            if (head_now.index == IRC_IDX_MODE && !wr_ok) begin
                mode_reg <= IRC_RST_MODE;
            end else if (do_write) begin
                unique case (head_now.index)
                    IRC_IDX_COMMON: common_reg <= wr_val;
                    IRC_IDX_MODE: mode_reg <= wr_val;
                    IRC_IDX_LED: led_reg <= wr_val;
                    default: led_reg <= led_reg;
                endcase
            end
        end
    end

    // Decoded configuration outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_power_normal <= 1'b0;
            o_receiver_output_enable <= 1'b0;
            o_led_enable <= 1'b0;
            o_ack_pulse_enable <= 1'b0;
            o_ir_mode <= IRC_RST_MODE;
            o_led_drive_level <= 4'h0;
            o_led_current_ma <= IRC_MA_0;
        end else begin
            o_power_normal <= common_reg[IRC_BIT_POWER];
            o_receiver_output_enable <= common_reg[IRC_BIT_RECEIVER_OUTPUT_ENABLE];
            o_led_enable <= common_reg[IRC_BIT_LED_EN];
            o_ack_pulse_enable <= common_reg[IRC_BIT_ACK_EN];
            o_ir_mode <= mode_reg;
            o_led_drive_level <= led_reg[7:4];
            if (led_reg[7]) begin
                o_led_current_ma <= IRC_MA_SWITCHED;
            end else begin
                unique case (led_reg[6:4])
                    3'd7: o_led_current_ma <= IRC_MA_7;
                    3'd6: o_led_current_ma <= IRC_MA_6;
                    3'd5: o_led_current_ma <= IRC_MA_5;
                    3'd4: o_led_current_ma <= IRC_MA_4;
                    3'd3: o_led_current_ma <= IRC_MA_3;
                    3'd2: o_led_current_ma <= IRC_MA_2;
                    3'd1: o_led_current_ma <= IRC_MA_1;
                    3'd0: o_led_current_ma <= IRC_MA_0;
                endcase
            end
        end
    end

endmodule : irc_serial_ctrl

// file: irc_serial_ctrl_asserts.sv
`timescale 1ns/1ps
module irc_serial_ctrl_asserts (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_tx_command_line,
    input wire logic o_rx_answer_line,
    input wire logic o_rx_answer_oe,
    input wire logic o_power_normal,
    input wire logic o_receiver_output_enable,
    input wire logic o_led_enable,
    input wire logic o_ack_pulse_enable,
    input wire logic [7:0] o_ir_mode,
    input wire logic [3:0] o_led_drive_level,
    input wire logic [9:0] o_led_current_ma
);
    localparam logic [9:0] MA_TAB [8] = '{10'h000, 10'h008, 10'h00F, 10'h01E,
                                          10'h02D, 10'h03C, 10'h07D, 10'h0FA};
    logic sclk_q = 1'b0;
    logic rise;
    logic [3:0] since_rise = 4'h0;
    logic [4:0] low_cnt = 5'h00;
    logic [3:0] ans_rises = 4'h0;

    // Raw serial clock rise, seen one system clock late
    assign rise = i_sclk && !sclk_q;
    always_ff @(posedge i_clk_sys) sclk_q <= i_sclk;
    // Age of the last serial clock rise, saturating so long idles stay legal
    always_ff @(posedge i_clk_sys)
        since_rise <= rise ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
    // Run of serial clock rises with the command line low
    always_ff @(posedge i_clk_sys)
        if (i_reset) low_cnt <= 5'h00;
        else if (rise) low_cnt <= i_tx_command_line ? 5'h00 : low_cnt + {4'h0, low_cnt != 5'h1F};
    // Serial clock rises seen while an answer occupies the line
    always_ff @(posedge i_clk_sys)
        if (!o_rx_answer_oe) ans_rises <= 4'h0;
        else if (rise && ans_rises != 4'hF) ans_rises <= ans_rises + 4'h1;

    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    a_reset_idle: assert property (disable iff (1'b0) i_reset |=> !o_rx_answer_oe && o_rx_answer_line)
        else $error("answer line driven during reset");
    a_reset_defaults: assert property ($fell(i_reset) |-> ##[1:2] (o_led_drive_level == 4'h7 &&
        o_ir_mode == 8'h00 && o_power_normal && o_receiver_output_enable && o_led_enable &&
        o_ack_pulse_enable)) else $error("defaults missing after reset");
    a_current_map: assert property ($stable(o_led_drive_level) |-> o_led_current_ma ==
        (o_led_drive_level[3] ? 10'h226 : MA_TAB[o_led_drive_level[2:0]]))
        else $error("emitter current does not match drive level");
    a_line_idle: assert property (!o_rx_answer_oe |-> o_rx_answer_line)
        else $error("released answer line not idle");
    a_answer_length: assert property (ans_rises <= 4'h8)
        else $error("answer longer than one byte");
    a_answer_on_edge: assert property ($rose(o_rx_answer_oe) |-> since_rise <= 4'h6)
        else $error("answer started away from a serial clock rise");
    a_answer_rx_enable: assert property ($rose(o_rx_answer_oe) |-> $past(o_receiver_output_enable))
        else $error("answer started with receiver output disabled");
    a_line_watchdog: assert property (rise && !i_tx_command_line && low_cnt == 5'h1D |->
        ##[1:8] (o_led_drive_level == 4'h7 && o_ir_mode == 8'h00 && o_ack_pulse_enable))
        else $error("low command line did not restore defaults");
    a_config_cause: assert property (!$stable({o_ir_mode, o_led_drive_level, o_power_normal}) |->
        since_rise <= 4'h8 || $past(i_reset, 2) || $past(i_reset, 3))
        else $error("configuration changed without serial traffic");
endmodule : irc_serial_ctrl_asserts

bind irc_serial_ctrl irc_serial_ctrl_asserts irc_serial_ctrl_asserts_i (
    .i_clk_sys, .i_reset, .i_sclk, .i_tx_command_line, .o_rx_answer_line, .o_rx_answer_oe,
    .o_power_normal, .o_receiver_output_enable, .o_led_enable, .o_ack_pulse_enable,
    .o_ir_mode, .o_led_drive_level, .o_led_current_ma
);

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import irc_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C;  // Arbitrary value
    localparam logic [7:0] PART = 8'hC3;  // Arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic sclk, tx, oe, line, rx_wire, pwr, rxen, leden, acken;
    logic [7:0] mode;
    logic [3:0] lvl;
    logic [9:0] ma;
    logic [31:0] rxv;
    logic [7:0] m_com, m_mode, m_led;
    int m_low = 0;
    int n_fail = 0;
    int samples_checked = 0;

    // Answer line has a pull-up, so a released line reads high
    assign rx_wire = oe ? line : 1'b1;
    initial forever #10 i_clk_sys = ~i_clk_sys;

    irc_serial_ctrl #(.MAKER_ID(MAKER), .PART_ID(PART)) irc_serial_ctrl_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sclk(sclk), .i_tx_command_line(tx),
        .o_rx_answer_line(line), .o_rx_answer_oe(oe), .o_power_normal(pwr),
        .o_receiver_output_enable(rxen), .o_led_enable(leden), .o_ack_pulse_enable(acken),
        .o_ir_mode(mode), .o_led_drive_level(lvl), .o_led_current_ma(ma));
    irc_ctrl_model irc_ctrl_model_i (.i_clk_sys(i_clk_sys), .i_rx(rx_wire), .o_sclk(sclk),
        .o_tx(tx));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [9:0] cur(input logic [3:0] c);
        int t[8] = '{0, 8, 15, 30, 45, 60, 125, 250};
        return c[3] ? 10'h226 : 10'(t[c[2:0]]);
    endfunction : cur

    function automatic logic [7:0] ext(input logic [7:0] e);
        case (e)
            8'h00: return MAKER;
            8'h01: return PART;
            8'h04: return 8'h24;
            8'h05: return 8'h30;
            8'h06: return 8'h03;
            8'h07: return 8'h0F;
            8'h08: return 8'h01;
            default: return 8'hFF;
        endcase
    endfunction : ext

    task automatic dflt();
        m_com = IRC_RST_COMMON;
        m_mode = IRC_RST_MODE;
        m_led = IRC_RST_LED;
    endtask : dflt

    // Send one frame with a random data setup point; the model follows the line monitor bit by bit
    task automatic frame(input logic [31:0] b, input int n);
        irc_ctrl_model_i.xfer(b, n, $urandom_range(3), rxv);
        for (int k = 0; k < n; k++) begin
            m_low = b[k] ? 0 : m_low + 1;
            if (m_low >= 30) dflt();
        end
    endtask : frame

    task automatic outs();
        repeat (4) @(posedge i_clk_sys);
        chk({pwr, rxen, leden, acken}, {m_com[0], m_com[1], m_com[2], m_com[4]});
        chk(mode, m_mode);
        chk({lvl, ma}, {m_led[7:4], cur(m_led[7:4])});
    endtask : outs

    task automatic wr(input logic [2:0] a, input logic [3:0] i, input logic [7:0] d);
        logic ack;
        logic ok;
        ack = a == IRC_ADDR_OWN && m_com[4] && m_com[1] && i < 4'h3;
        ok = i < 4'h3 && (a == IRC_ADDR_OWN || a == IRC_ADDR_BCAST);
        frame({2'b00, d, 1'b1, a, i, 3'b110}, 21);
        if (i == 4'h1 && !(d inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h08})) begin
            ack = 1'b0;
            d = 8'h00;
        end
        if (ok && i == 4'h0) m_com = d & IRC_MASK_COMMON;
        if (ok && i == 4'h1) m_mode = d;
        if (ok && i == 4'h2) m_led = d & IRC_MASK_LED;
        outs();
        chk(rxv[19], !ack);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [3:0] i, input logic [7:0] e);
        logic [7:0] x;
        logic rsp;
        int s;
        s = i == 4'hF ? 18 : 10;
        x = i == 4'h0 ? m_com : i == 4'h1 ? m_mode : i == 4'h2 ? m_led : ext(e);
        rsp = a == IRC_ADDR_OWN && m_com[1] && (i < 4'h3 || (i == 4'hF && e inside {0, 1, [4:8]}));
        frame({e, a, i, 3'b010}, s + 8);
        outs();
        chk(rxv[s+:8], rsp ? x : 8'hFF);
    endtask : rd

    task automatic sp(input logic [2:0] a);
        logic ack;
        ack = a == IRC_ADDR_OWN && m_com[4] && m_com[1];
        frame({2'b00, 1'b0, a, 4'hD, 3'b110}, 12);
        if (a == IRC_ADDR_OWN || a == IRC_ADDR_BCAST) dflt();
        outs();
        chk(rxv[11], !ack);
    endtask : sp

    // Hang guard
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        n_fail++;
        complete_run();
    end

    initial begin
        logic [7:0] mv [7];
        mv = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h05, 8'h00, 8'h42};
        void'($urandom(32'h1333));
        dflt();
        repeat (6) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        outs();
        for (int c = 0; c < 16; c++) begin
            wr(IRC_ADDR_OWN, IRC_IDX_LED, {4'(c), 4'($urandom_range(15))});
            rd(IRC_ADDR_OWN, IRC_IDX_LED, 8'h00);
        end
        for (int e = 0; e < 12; e++) rd(IRC_ADDR_OWN, IRC_IDX_EXT, 8'(e));
        rd(IRC_ADDR_OWN, IRC_IDX_EXT, 8'($urandom_range(255, 9)));
        foreach (mv[j]) wr(IRC_ADDR_OWN, IRC_IDX_MODE, mv[j]);
        for (int i = 3; i < 16; i++) begin
            if (i != 13) wr(IRC_ADDR_OWN, 4'(i), 8'($urandom_range(255)));
            if (i != 15) rd(IRC_ADDR_OWN, 4'(i), 8'h00);
        end
        wr(IRC_ADDR_BCAST, IRC_IDX_LED, 8'h20);
        rd(IRC_ADDR_BCAST, IRC_IDX_LED, 8'h00);
        wr(3'b010, IRC_IDX_LED, 8'h50);
        rd(3'b100, IRC_IDX_MODE, 8'h00);
        wr(IRC_ADDR_OWN, IRC_IDX_COMMON, 8'h07);
        wr(IRC_ADDR_OWN, IRC_IDX_LED, 8'h60);
        wr(IRC_ADDR_OWN, IRC_IDX_COMMON, 8'h15);
        rd(IRC_ADDR_OWN, IRC_IDX_LED, 8'h00);
        sp(IRC_ADDR_OWN);
        wr(IRC_ADDR_OWN, IRC_IDX_LED, 8'h30);
        sp(IRC_ADDR_BCAST);
        wr(IRC_ADDR_OWN, IRC_IDX_LED, 8'hF0);
        frame(32'h0000_0000, 27);
        outs();
        frame(32'h0000_0000, 1);
        outs();
        rd(IRC_ADDR_OWN, IRC_IDX_COMMON, 8'h00);
        wr(IRC_ADDR_OWN, IRC_IDX_COMMON, 8'h0A);
        rd(IRC_ADDR_OWN, IRC_IDX_COMMON, 8'h00);
        complete_run();
    end
endmodule : tb
